// ---- src/drpc_pkg.sv ----
// Package: commands and timing counts of the refresh and power-down control
package drpc_pkg;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int REFI_NORMAL_PS = 7812500;
   localparam int REFI_HOT_PS = 3900000;
   // Longest times round down
   localparam int REFI_NORMAL_CYC = REFI_NORMAL_PS / CLK_PERIOD_PS;
   localparam int REFI_HOT_CYC = REFI_HOT_PS / CLK_PERIOD_PS;
   localparam int RFC_NS = 128;
   // Least times round up
   localparam int RFC_CYC = (RFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int XSNR_NS = 138;
   localparam int XSNR_CYC = (XSNR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int XSRD_CYC = 200;
   localparam int CKE_MIN_CYC = 3;
   localparam int XP_CYC = 2;
   localparam int XARD_CYC = 2;
   localparam int XARDS_CYC = 7;
   localparam int WTR_MIN_CYC = 2;
   localparam int RPST_CYC = 1;
   localparam int CNT_W = 16;
   localparam int NUM_BANKS = 8;
   localparam int MR_SLOW_EXIT_BIT = 12;
   typedef enum logic [2:0]
   {
      DRPC_CMD_NOP,
      DRPC_CMD_DESEL,
      DRPC_CMD_ACT,
      DRPC_CMD_READ,
      DRPC_CMD_WRITE,
      DRPC_CMD_PRE,
      DRPC_CMD_REF,
      DRPC_CMD_LM
   } drpc_cmd_type;
endpackage

// ---- src/drpc_if.sv ----
// Interface: command, CKE and ODT link between controller and memory device
`timescale 1ns/1ps
interface drpc_if;
   drpc_pkg::drpc_cmd_type cmd;
   logic [2:0] bank;
   logic a10;
   logic cke;
   logic odt;
   modport ctrl
   (
      output cmd,
      output bank,
      output a10,
      output cke,
      output odt
   );
   modport dev
   (
      input cmd,
      input bank,
      input a10,
      input cke,
      input odt
   );
endinterface

// ---- src/drpc_ctrl.sv ----
// Controller end: refresh scheduling, self-refresh and power-down sequencing
`timescale 1ns/1ps
module drpc_ctrl
#(
   parameter int REFI_NORMAL = drpc_pkg::REFI_NORMAL_CYC,
   parameter int REFI_HOT = drpc_pkg::REFI_HOT_CYC
)
(
   input wire ref_clk,
   input wire nrst,
   drpc_if.ctrl mem,
   input wire logic hot,
   input wire logic req_valid,
   input wire drpc_pkg::drpc_cmd_type req_cmd,
   input wire logic [2:0] req_bank,
   input wire logic req_a10,
   input wire logic req_odt,
   input wire logic pd_req,
   input wire logic sr_req,
   input wire logic slow_exit,
   input wire logic dll_locked,
   output logic req_ready,
   output logic in_pd,
   output logic in_sr,
   output logic dll_reset_needed
);
   typedef enum logic [2:0]
   {
      DRPC_C_RUN,
      DRPC_C_PREALL,
      DRPC_C_REF,
      DRPC_C_PD,
      DRPC_C_SR,
      DRPC_C_EXIT
   } drpc_cstate_type;

   drpc_cstate_type state, next_state;
   logic [drpc_pkg::CNT_W-1:0] refi, next_refi;
   logic [drpc_pkg::CNT_W-1:0] wait_cnt, next_wait_cnt;
   logic [drpc_pkg::CNT_W-1:0] rd_wait, next_rd_wait;
   logic [drpc_pkg::CNT_W-1:0] busy, next_busy;
   logic [drpc_pkg::CNT_W-1:0] cke_hold, next_cke_hold;
   logic [drpc_pkg::NUM_BANKS-1:0] open_b, next_open_b;
   logic pend_ref, next_pend_ref;
   logic sr_go, next_sr_go;
   logic cke, next_cke;
   logic odt, next_odt;
   drpc_pkg::drpc_cmd_type cmd, next_cmd;
   logic [2:0] bank, next_bank;
   logic a10, next_a10;
   logic ready, next_ready;
   logic dllr, next_dllr;
   logic unlocked_at_entry, next_unlocked_at_entry;
   logic next_in_pd, next_in_sr;

   assign mem.cmd = cmd;
   assign mem.bank = bank;
   assign mem.a10 = a10;
   assign mem.cke = cke;
   assign mem.odt = odt;
   assign req_ready = ready;
   assign dll_reset_needed = dllr;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state = state;
      // Hot case tightens the interval
      next_refi = (refi != '0) ? refi - 1'b1 :
         hot ? drpc_pkg::CNT_W'(REFI_HOT) : drpc_pkg::CNT_W'(REFI_NORMAL);
      next_wait_cnt = (wait_cnt == '0) ? '0 : wait_cnt - 1'b1;
      next_rd_wait = (rd_wait == '0) ? '0 : rd_wait - 1'b1;
      next_busy = (busy == '0) ? '0 : busy - 1'b1;
      next_cke_hold = (cke_hold == '0) ? '0 : cke_hold - 1'b1;
      next_open_b = open_b;
      next_pend_ref = pend_ref | (refi == '0);
      next_sr_go = sr_go;
      next_cke = cke;
      next_odt = odt;
      next_cmd = drpc_pkg::DRPC_CMD_NOP;
      next_bank = '0;
      next_a10 = 1'b0;
      next_ready = 1'b0;
      next_dllr = dllr;
      next_unlocked_at_entry = unlocked_at_entry;
      unique case (state)
         DRPC_C_RUN:
         begin
            if (pend_ref || sr_req)
            begin
               next_sr_go = sr_req && !pend_ref;
               next_odt = 1'b0;
               if (busy == '0)
               begin
                  next_state = DRPC_C_PREALL;
               end
            end
            else if (pd_req && busy == '0 && cke_hold == '0)
            begin
               // Entry with NOP; refresh timer keeps running to bound the stay
               next_cke = 1'b0;
               next_odt = 1'b0;
               next_cke_hold = drpc_pkg::CNT_W'(drpc_pkg::CKE_MIN_CYC);
               next_unlocked_at_entry = !dll_locked;
               next_state = DRPC_C_PD;
            end
            else
            begin
               // Dropped before a due refresh, so a due refresh never discards a taken request
               next_ready = (refi != '0);
               next_odt = req_odt && rd_wait == '0;
               if (req_valid && ready)
               begin
                  if (!(req_cmd == drpc_pkg::DRPC_CMD_READ && rd_wait != '0))
                  begin
                     next_cmd = req_cmd;
                     next_bank = req_bank;
                     next_a10 = req_a10;
                     unique case (req_cmd)
                        drpc_pkg::DRPC_CMD_ACT: next_open_b[req_bank] = 1'b1;
                        drpc_pkg::DRPC_CMD_PRE:
                           next_open_b = req_a10 ? '0 : open_b & ~(8'h01 << req_bank);
                        drpc_pkg::DRPC_CMD_READ:
                        begin
                           next_busy = drpc_pkg::CNT_W'(4 + drpc_pkg::RPST_CYC);
                           next_dllr = 1'b0;
                        end
                        drpc_pkg::DRPC_CMD_WRITE:
                           next_busy = drpc_pkg::CNT_W'(6 + drpc_pkg::WTR_MIN_CYC);
                        drpc_pkg::DRPC_CMD_LM: next_busy = drpc_pkg::CNT_W'(2);
                        default: next_open_b = open_b;
                     endcase
                  end
               end
            end
         end
         DRPC_C_PREALL:
         begin
            if (open_b != '0)
            begin
               next_cmd = drpc_pkg::DRPC_CMD_PRE;
               next_a10 = 1'b1;
               next_open_b = '0;
               next_busy = drpc_pkg::CNT_W'(4);
            end
            else if (busy == '0 && cke_hold == '0)
            begin
               next_cmd = drpc_pkg::DRPC_CMD_REF;
               // A new interval expiring now must not be lost
               next_pend_ref = (refi == '0);
               if (sr_go)
               begin
                  next_cke = 1'b0;
                  next_cke_hold = drpc_pkg::CNT_W'(drpc_pkg::CKE_MIN_CYC);
                  next_state = DRPC_C_SR;
               end
               else
               begin
                  next_busy = drpc_pkg::CNT_W'(drpc_pkg::RFC_CYC);
                  next_state = DRPC_C_REF;
               end
            end
         end
         DRPC_C_REF: next_state = (busy == '0) ? DRPC_C_RUN : state;
         DRPC_C_PD:
         begin
            if ((!pd_req || pend_ref) && cke_hold == '0)
            begin
               next_cke = 1'b1;
               next_cke_hold = drpc_pkg::CNT_W'(drpc_pkg::CKE_MIN_CYC);
               next_wait_cnt = drpc_pkg::CNT_W'(drpc_pkg::XP_CYC);
               next_rd_wait = slow_exit ? drpc_pkg::CNT_W'(drpc_pkg::XARDS_CYC) :
                  drpc_pkg::CNT_W'(drpc_pkg::XARD_CYC);
               next_dllr = unlocked_at_entry;
               next_state = DRPC_C_EXIT;
            end
         end
         DRPC_C_SR:
         begin
            next_pend_ref = 1'b0;
            if (!sr_req && cke_hold == '0)
            begin
               next_cke = 1'b1;
               next_cke_hold = drpc_pkg::CNT_W'(drpc_pkg::XSRD_CYC);
               next_wait_cnt = drpc_pkg::CNT_W'(drpc_pkg::XSNR_CYC);
               next_rd_wait = drpc_pkg::CNT_W'(drpc_pkg::XSRD_CYC);
               next_state = DRPC_C_EXIT;
            end
         end
         DRPC_C_EXIT: next_state = (wait_cnt == '0) ? DRPC_C_RUN : state;
      endcase
      next_in_pd = (next_state == DRPC_C_PD);
      next_in_sr = (next_state == DRPC_C_SR);
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= DRPC_C_RUN;
         refi <= '0;
         wait_cnt <= '0;
         rd_wait <= '0;
         busy <= '0;
         cke_hold <= '0;
         open_b <= '0;
         pend_ref <= 1'b0;
         sr_go <= 1'b0;
         cke <= 1'b1;
         odt <= 1'b0;
         cmd <= drpc_pkg::DRPC_CMD_NOP;
         bank <= '0;
         a10 <= 1'b0;
         ready <= 1'b0;
         dllr <= 1'b0;
         unlocked_at_entry <= 1'b0;
         in_pd <= 1'b0;
         in_sr <= 1'b0;
      end
      else
      begin
         state <= next_state;
         refi <= next_refi;
         wait_cnt <= next_wait_cnt;
         rd_wait <= next_rd_wait;
         busy <= next_busy;
         cke_hold <= next_cke_hold;
         open_b <= next_open_b;
         pend_ref <= next_pend_ref;
         sr_go <= next_sr_go;
         cke <= next_cke;
         odt <= next_odt;
         cmd <= next_cmd;
         bank <= next_bank;
         a10 <= next_a10;
         ready <= next_ready;
         dllr <= next_dllr;
         unlocked_at_entry <= next_unlocked_at_entry;
         in_pd <= next_in_pd;
         in_sr <= next_in_sr;
      end
   end
endmodule

// ---- src/drpc_dev.sv ----
// Device end: tracks refresh, self refresh and power-down state from CKE and commands
`timescale 1ns/1ps
module drpc_dev
(
   input wire ref_clk,
   input wire nrst,
   drpc_if.dev mem,
   output logic refreshing,
   output logic self_refresh,
   output logic pd_precharge,
   output logic pd_active,
   output logic buffers_on,
   output logic dll_frozen,
   output logic exit_busy,
   output logic [7:0] open_banks
);
   typedef enum logic [2:0]
   {
      DRPC_D_IDLE,
      DRPC_D_REF,
      DRPC_D_SR,
      DRPC_D_PPD,
      DRPC_D_APD
   } drpc_dstate_type;

   drpc_dstate_type state, next_state;
   logic cke_prev, next_cke_prev;
   logic [drpc_pkg::CNT_W-1:0] cnt, next_cnt;
   logic [drpc_pkg::CNT_W-1:0] xcnt, next_xcnt;
   logic [7:0] open_b, next_open_b;
   logic is_nop;
   logic next_refreshing, next_self_refresh, next_pd_precharge, next_pd_active;
   logic next_buffers_on, next_dll_frozen, next_exit_busy;

   assign is_nop = (mem.cmd == drpc_pkg::DRPC_CMD_NOP) || (mem.cmd == drpc_pkg::DRPC_CMD_DESEL);
   assign open_banks = open_b;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state = state;
      next_cke_prev = mem.cke;
      next_cnt = (cnt == '0) ? '0 : cnt - 1'b1;
      next_xcnt = (xcnt == '0) ? '0 : xcnt - 1'b1;
      next_open_b = open_b;
      unique case (state)
         DRPC_D_IDLE:
         begin
            if (cke_prev && !mem.cke)
            begin
               if (mem.cmd == drpc_pkg::DRPC_CMD_REF)
               begin
                  next_state = DRPC_D_SR;
               end
               else if (is_nop)
               begin
                  // Mode chosen by bank state at entry
                  next_state = (open_b == '0) ? DRPC_D_PPD : DRPC_D_APD;
               end
            end
            else if (mem.cke)
            begin
               unique case (mem.cmd)
                  drpc_pkg::DRPC_CMD_ACT: next_open_b[mem.bank] = 1'b1;
                  drpc_pkg::DRPC_CMD_PRE: next_open_b = mem.a10 ? '0 : open_b & ~(8'h01 << mem.bank);
                  drpc_pkg::DRPC_CMD_REF:
                  begin
                     next_cnt = drpc_pkg::CNT_W'(drpc_pkg::RFC_CYC);
                     next_state = DRPC_D_REF;
                  end
                  default: next_open_b = open_b;
               endcase
            end
         end
         DRPC_D_REF:
         begin
            if (cnt <= 1)
            begin
               next_state = DRPC_D_IDLE;
            end
         end
         DRPC_D_SR:
         begin
            // Inputs other than CKE ignored
            if (mem.cke)
            begin
               next_xcnt = drpc_pkg::CNT_W'(drpc_pkg::XSRD_CYC);
               next_state = DRPC_D_IDLE;
            end
         end
         DRPC_D_PPD, DRPC_D_APD:
         begin
            if (mem.cke && is_nop)
            begin
               next_xcnt = drpc_pkg::CNT_W'(drpc_pkg::XP_CYC);
               next_state = DRPC_D_IDLE;
            end
         end
      endcase
      next_refreshing = (next_state == DRPC_D_REF);
      next_self_refresh = (next_state == DRPC_D_SR);
      next_pd_precharge = (next_state == DRPC_D_PPD);
      next_pd_active = (next_state == DRPC_D_APD);
      // Only CK, ODT and CKE stay alive in power-down
      next_buffers_on = (next_state == DRPC_D_IDLE) || (next_state == DRPC_D_REF);
      next_dll_frozen = (next_state == DRPC_D_PPD) || (next_state == DRPC_D_SR);
      next_exit_busy = (next_xcnt != '0);
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= DRPC_D_IDLE;
         cke_prev <= 1'b1;
         cnt <= '0;
         xcnt <= '0;
         open_b <= '0;
         refreshing <= 1'b0;
         self_refresh <= 1'b0;
         pd_precharge <= 1'b0;
         pd_active <= 1'b0;
         buffers_on <= 1'b1;
         dll_frozen <= 1'b0;
         exit_busy <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cke_prev <= next_cke_prev;
         cnt <= next_cnt;
         xcnt <= next_xcnt;
         open_b <= next_open_b;
         refreshing <= next_refreshing;
         self_refresh <= next_self_refresh;
         pd_precharge <= next_pd_precharge;
         pd_active <= next_pd_active;
         buffers_on <= next_buffers_on;
         dll_frozen <= next_dll_frozen;
         exit_busy <= next_exit_busy;
      end
   end
endmodule

// ---- test/drpc_properties.sv ----
// Checker: timing relations on the controller to device link
`timescale 1ns/1ps
module drpc_properties
(
   input wire ref_clk,
   input wire nrst,
   input wire drpc_pkg::drpc_cmd_type cmd,
   input wire logic [2:0] bank,
   input wire logic a10,
   input wire logic cke,
   input wire logic odt
);
   localparam int XSNR = drpc_pkg::XSNR_CYC;
   logic quiet, sr_in, in_sr, next_in_sr;
   logic [7:0] srx, next_srx, banks, next_banks;
   logic [5:0] rfc, next_rfc;
   assign quiet = cmd inside {drpc_pkg::DRPC_CMD_NOP, drpc_pkg::DRPC_CMD_DESEL};
   assign sr_in = cmd == drpc_pkg::DRPC_CMD_REF && !cke;
   ////////////////////////////////////////////////////////////
   // Device state rebuilt from the link alone, not from the device outputs
   always_comb
   begin
      next_in_sr = sr_in || (in_sr && !cke);
      next_srx = 8'h00;
      next_rfc = (rfc != 6'h00) ? rfc - 6'h01 : 6'h00;
      next_banks = banks;
      if (in_sr && cke)
         next_srx = 8'h01;
      else if (!sr_in && srx != 8'h00 && srx < 8'(drpc_pkg::XSRD_CYC - 1))
         next_srx = srx + 8'h01;
      if (cmd == drpc_pkg::DRPC_CMD_REF && cke)
         next_rfc = 6'(drpc_pkg::RFC_CYC - 1);
      if (cmd == drpc_pkg::DRPC_CMD_ACT)
         next_banks[bank] = 1'b1;
      if (cmd == drpc_pkg::DRPC_CMD_PRE)
         next_banks = a10 ? 8'h00 : banks & ~(8'h01 << bank);
   end
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         in_sr <= 1'b0;
         srx <= 8'h00;
         rfc <= 6'h00;
         banks <= 8'h00;
      end
      else
      begin
         in_sr <= next_in_sr;
         srx <= next_srx;
         rfc <= next_rfc;
         banks <= next_banks;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // Read burst done at postamble, write burst needs recovery as well
   sequence s_rd_burst;
      cke [*5];
   endsequence
   sequence s_wr_burst;
      cke [*6];
   endsequence
   property p_cke_hold;
      $changed(cke) |=> $stable(cke) [*2];
   endproperty
   a_cke_hold: assert property (p_cke_hold) else $error("cke level too short");
   property p_pd_enter;
      $fell(cke) |-> quiet || cmd == drpc_pkg::DRPC_CMD_REF;
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("bad cke fall");
   property p_pd_leave;
      $rose(cke) |-> quiet;
   endproperty
   a_pd_leave: assert property (p_pd_leave) else $error("bad cke rise");
   property p_ref_busy;
      rfc != 6'h00 |-> quiet;
   endproperty
   a_ref_busy: assert property (p_ref_busy) else $error("command in refresh");
   property p_ref_idle;
      cmd == drpc_pkg::DRPC_CMD_REF |-> banks == 8'h00;
   endproperty
   a_ref_idle: assert property (p_ref_idle) else $error("refresh with open bank");
   property p_sr_odt;
      sr_in || srx != 8'h00 |-> !odt;
   endproperty
   a_sr_odt: assert property (p_sr_odt) else $error("odt on near self refresh");
   property p_xsnr;
      srx != 8'h00 && srx < 8'(XSNR) |-> quiet;
   endproperty
   a_xsnr: assert property (p_xsnr) else $error("command before exit wait");
   property p_xsrd_read;
      srx != 8'h00 |-> cmd != drpc_pkg::DRPC_CMD_READ;
   endproperty
   a_xsrd_read: assert property (p_xsrd_read) else $error("early read");
   property p_xsrd_cke;
      srx != 8'h00 && !cke |-> sr_in && srx >= 8'(XSNR);
   endproperty
   a_xsrd_cke: assert property (p_xsrd_cke) else $error("cke low after exit");
   property p_burst;
      cmd == drpc_pkg::DRPC_CMD_READ |-> s_rd_burst;
   endproperty
   a_burst: assert property (p_burst) else $error("cke low in read");
   property p_wr_burst;
      cmd == drpc_pkg::DRPC_CMD_WRITE |-> s_wr_burst;
   endproperty
   a_wr_burst: assert property (p_wr_burst) else $error("cke low in write");
endmodule

// ---- test/tb_top.sv ----
// Testbench: both ends joined over the link, driven from the controller user side
`timescale 1ns/1ps
module tb_top;
   localparam int REFI_N = 400;
   localparam int REFI_H = 200;
   localparam drpc_pkg::drpc_cmd_type ACT = drpc_pkg::DRPC_CMD_ACT;
   localparam drpc_pkg::drpc_cmd_type RD = drpc_pkg::DRPC_CMD_READ;
   localparam drpc_pkg::drpc_cmd_type PRE = drpc_pkg::DRPC_CMD_PRE;
   logic ref_clk;
   logic nrst = 1'b0;
   logic hot = 1'b0;
   logic req_valid = 1'b0;
   logic req_a10 = 1'b0;
   logic req_odt = 1'b0;
   logic pd_req = 1'b0;
   logic sr_req = 1'b0;
   logic slow_exit = 1'b0;
   logic dll_locked = 1'b1;
   logic [2:0] req_bank = 3'h0;
   drpc_pkg::drpc_cmd_type req_cmd = drpc_pkg::DRPC_CMD_NOP;
   logic req_ready, in_pd, in_sr, dll_reset_needed, refreshing, self_refresh;
   logic pd_precharge, pd_active, buffers_on, dll_frozen, exit_busy, cke_q;
   logic [7:0] open_banks;
   int cyc = 0, n_ref = 0, n_rd = 0, rise_cyc = 0, rd_cyc = 0, act_cyc = 0;
   int n_fail = 0, samples_checked = 0;
   drpc_if mem ();
   drpc_ctrl #(.REFI_NORMAL(REFI_N), .REFI_HOT(REFI_H)) u_drpc_ctrl (.ref_clk(ref_clk),
      .nrst(nrst), .mem(mem), .hot(hot), .req_valid(req_valid), .req_cmd(req_cmd),
      .req_bank(req_bank), .req_a10(req_a10), .req_odt(req_odt), .pd_req(pd_req),
      .sr_req(sr_req), .slow_exit(slow_exit), .dll_locked(dll_locked),
      .req_ready(req_ready), .in_pd(in_pd), .in_sr(in_sr), .dll_reset_needed(dll_reset_needed));
   drpc_dev u_drpc_dev (.ref_clk(ref_clk), .nrst(nrst), .mem(mem), .refreshing(refreshing),
      .self_refresh(self_refresh), .pd_precharge(pd_precharge), .pd_active(pd_active),
      .buffers_on(buffers_on), .dll_frozen(dll_frozen), .exit_busy(exit_busy),
      .open_banks(open_banks));
   drpc_properties u_drpc_properties (.ref_clk(ref_clk), .nrst(nrst), .cmd(mem.cmd),
      .bank(mem.bank), .a10(mem.a10), .cke(mem.cke), .odt(mem.odt));
   ////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_on(input int s, input logic v);
      int k;
      k = 0;
      while ((s == 0 ? in_pd : s == 1 ? in_sr : req_ready) !== v && k < 3000)
      begin
         tick(1);
         k++;
      end
      check("wait", 16'(k < 3000), 16'h0001);
   endtask
   // Ends one cycle after release so valid is low for a clock edge between back-to-back calls
   task automatic issue(input drpc_pkg::drpc_cmd_type c, input logic [2:0] b, input logic a);
      wait_on(2, 1'b1);
      req_valid = 1'b1;
      req_cmd = c;
      req_bank = b;
      req_a10 = a;
      tick(1);
      req_valid = 1'b0;
      tick(1);
   endtask
   task automatic sync_ref;
      int n0;
      n0 = n_ref;
      while (n_ref == n0)
         tick(1);
      check("refreshing", 16'(refreshing), 16'h0001);
      tick(drpc_pkg::RFC_CYC + 4);
      check("refreshing", 16'(refreshing), 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      cke_q <= mem.cke;
      if (mem.cke === 1'b1 && cke_q === 1'b0)
         rise_cyc <= cyc;
      if (mem.cmd === drpc_pkg::DRPC_CMD_REF)
         n_ref <= n_ref + 1;
      if (mem.cmd === ACT)
         act_cyc <= cyc;
      if (mem.cmd === RD)
      begin
         n_rd <= n_rd + 1;
         rd_cyc <= cyc;
      end
      if (cyc == 20000)
      begin
         n_fail++;
         complete_run;
      end
   end
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial
   begin
      int k;
      repeat (2) @(posedge ref_clk);
      #1;
      check("reset link", 16'({mem.cke, mem.odt}), 16'h0002);
      nrst = 1'b1;
      for (int h = 0; h < 2; h++)
      begin
         hot = h[0];
         k = n_ref;
         tick(8 * REFI_N);
         k = n_ref - k - 8 * (h + 1);
         check("refresh count", 16'(k >= -1 && k <= 2), 16'h0001);
      end
      hot = 1'b0;
      // Active power-down, slow exit with unlocked DLL, then fast exit
      for (int s = 1; s >= 0; s--)
      begin
         slow_exit = s[0];
         dll_locked = !s[0];
         sync_ref;
         issue(ACT, 3'h3, 1'b0);
         tick(2);
         check("open banks", 16'(open_banks), 16'h0008);
         pd_req = 1'b1;
         wait_on(0, 1'b1);
         tick(2);
         check("active pd", 16'({pd_active, pd_precharge, buffers_on, dll_frozen}), 16'h0008);
         dll_locked = 1'b1;
         pd_req = 1'b0;
         wait_on(0, 1'b0);
         tick(1);
         check("dll reset", 16'(dll_reset_needed), 16'(s));
         k = n_rd;
         while (n_rd == k)
            issue(RD, 3'h3, 1'b0);
         k = s ? drpc_pkg::XARDS_CYC : drpc_pkg::XARD_CYC;
         check("read delay", 16'(rd_cyc - rise_cyc >= k), 16'h0001);
         tick(1);
         check("dll reset", 16'(dll_reset_needed), 16'h0000);
         issue(PRE, 3'h0, 1'b1);
      end
      sync_ref;
      issue(ACT, 3'h1, 1'b0);
      issue(drpc_pkg::DRPC_CMD_WRITE, 3'h1, 1'b0);
      issue(PRE, 3'h1, 1'b0);
      pd_req = 1'b1;
      wait_on(0, 1'b1);
      tick(2);
      check("precharge pd", 16'({pd_active, pd_precharge, buffers_on, dll_frozen, open_banks}), 16'h0500);
      k = n_ref;
      tick(REFI_N + 100);
      check("refresh in pd", 16'(n_ref > k), 16'h0001);
      pd_req = 1'b0;
      wait_on(0, 1'b0);
      tick(drpc_pkg::XP_CYC + 2);
      check("pd left", 16'({buffers_on, dll_frozen}), 16'h0002);
      // Self refresh with termination requested beforehand
      sync_ref;
      req_odt = 1'b1;
      issue(ACT, 3'h2, 1'b0);
      req_odt = 1'b0;
      sr_req = 1'b1;
      wait_on(1, 1'b1);
      tick(2);
      check("self refresh", 16'({self_refresh, mem.odt, open_banks}), 16'h0200);
      tick(20);
      check("sr held", 16'(self_refresh), 16'h0001);
      sr_req = 1'b0;
      wait_on(1, 1'b0);
      issue(ACT, 3'h2, 1'b0);
      tick(1);
      check("xsnr", 16'(act_cyc - rise_cyc >= drpc_pkg::XSNR_CYC), 16'h0001);
      k = n_rd;
      issue(RD, 3'h2, 1'b0);
      tick(3);
      check("early read", 16'({n_rd - k, exit_busy}), 16'h0001);
      while (cyc - rise_cyc < drpc_pkg::XSRD_CYC + 2)
         tick(1);
      check("exit busy", 16'(exit_busy), 16'h0000);
      issue(RD, 3'h2, 1'b0);
      tick(3);
      check("late read", 16'(n_rd - k), 16'h0001);
      complete_run;
   end
endmodule
